//--- hdl/tim_cc_pkg.sv
// Package: register map, field layout and types for the capture/compare block
`default_nettype none
package tim_cc_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CHAN0_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CHAN1_CTRL = 8'h04;
	localparam logic [7:0] ADDR_CHAN0_HIGH = 8'h08;
	localparam logic [7:0] ADDR_CHAN0_LOW = 8'h0c;
	localparam logic [7:0] ADDR_CHAN1_HIGH = 8'h10;
	localparam logic [7:0] ADDR_CHAN1_LOW = 8'h14;
	localparam logic [7:0] ADDR_CNT_CTRL = 8'h18;
	localparam logic [7:0] ADDR_CNT_MOD = 8'h1c;
	localparam logic [7:0] ADDR_CNT_VALUE = 8'h20;
	localparam logic [7:0] ADDR_PIN_STATE = 8'h24;

	// ------------------------------------------------------------
	// Channel control/status fields
	// ------------------------------------------------------------
	localparam int BIT_FLAG = 7;
	localparam int BIT_IRQ_EN = 6;
	localparam int BIT_BUF_SEL = 5;
	localparam int BIT_MODE_A = 4;
	localparam int BIT_ELS_HI = 3;
	localparam int BIT_ELS_LO = 2;
	localparam int BIT_OVF_TOG = 1;
	localparam int BIT_FULL_DUTY = 0;

	// Counter control fields
	localparam int BIT_CNT_OVF_FLAG = 7;
	localparam int BIT_CNT_HALT = 5;
	localparam int BIT_CNT_CLEAR = 4;

	// ------------------------------------------------------------
	// Edge/level encodings
	// ------------------------------------------------------------
	localparam logic [1:0] ELS_OFF = 2'h0;
	localparam logic [1:0] ELS_RISE_TOG = 2'h1;
	localparam logic [1:0] ELS_FALL_CLR = 2'h2;
	localparam logic [1:0] ELS_BOTH_SET = 2'h3;

	localparam logic [15:0] MOD_RESET = 16'hffff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Per-channel configuration, decoded from the control register
	typedef struct packed {
		logic irq_en;
		logic buf_sel;
		logic mode_a;
		logic [1:0] els;
		logic ovf_tog;
		logic full_duty;
	} chan_cfg_t;

	// Per-channel event pulses toward the register file
	typedef struct packed {
		logic event_hit;
		logic [15:0] capture;
	} chan_evt_t;

endpackage : tim_cc_pkg
`default_nettype wire

//--- hdl/tim_cc_pin_sync.sv
// Three-stage synchroniser for the channel input pins
`timescale 1ns/1ps
`default_nettype none
module tim_cc_pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Pins
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_rise,
	output logic [WIDTH-1:0] pin_fall
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	logic [WIDTH-1:0] level_ff;

	// Level accepted only once the second and third stages agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			level_ff <= '0;
		end else begin
			s1_ff <= pin_async;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			level_ff <= (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
		end
	end

	assign pin_rise = s2_ff & s3_ff & ~level_ff;
	assign pin_fall = ~s2_ff & ~s3_ff & level_ff;
endmodule : tim_cc_pin_sync
`default_nettype wire

//--- hdl/tim_cc_channel.sv
// One capture/compare channel: event detection and pin action
`timescale 1ns/1ps
`default_nettype none
module tim_cc_channel (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Configuration and timer state
	input wire tim_cc_pkg::chan_cfg_t cfg,
	input wire logic enabled,
	input wire logic [15:0] count,
	input wire logic [15:0] compare,
	input wire logic ovf_tick,
	input wire logic match_block,
	input wire logic capture_block,
	// Pin edges
	input wire logic pin_rise,
	input wire logic pin_fall,
	// Results
	output tim_cc_pkg::chan_evt_t evt,
	output logic pin_out_ff,
	output logic pin_oe_ff
);
	logic is_out;
	logic is_cap;
	logic edge_hit;
	logic match_hit;
	logic full_ff;
	logic nxt_pin;

	assign is_out = cfg.buf_sel | cfg.mode_a;
	assign is_cap = enabled && cfg.els != tim_cc_pkg::ELS_OFF && !is_out;

	assign edge_hit = (cfg.els[0] & pin_rise) | (cfg.els[1] & pin_fall);
	assign match_hit = enabled && is_out && !match_block && count == compare;

	always_comb begin
		evt.event_hit = 1'b0;
		evt.capture = count;
		if (is_cap && edge_hit && !capture_block)
			evt.event_hit = 1'b1;
		if (match_hit && (cfg.els != tim_cc_pkg::ELS_OFF || !cfg.buf_sel))
			evt.event_hit = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			full_ff <= 1'b0;
		else if (ovf_tick)
			full_ff <= cfg.full_duty & cfg.ovf_tog;
	end

	always_comb begin
		nxt_pin = pin_out_ff;
		// preset level: mode A 1 gives low
		if (!enabled || cfg.els == tim_cc_pkg::ELS_OFF) begin
			nxt_pin = !cfg.mode_a;
		end else if (is_out) begin
			if (ovf_tick && cfg.ovf_tog) begin
				nxt_pin = (cfg.full_duty | full_ff) ? 1'b1 : !pin_out_ff;
			end else if (full_ff) begin
				nxt_pin = 1'b1;
			end else if (match_hit) begin
				unique case (cfg.els)
					tim_cc_pkg::ELS_RISE_TOG: nxt_pin = !pin_out_ff;
					tim_cc_pkg::ELS_FALL_CLR: nxt_pin = 1'b0;
					tim_cc_pkg::ELS_BOTH_SET: nxt_pin = 1'b1;
					default: nxt_pin = pin_out_ff;
				endcase
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out_ff <= 1'b1;
			pin_oe_ff <= 1'b0;
		end else begin
			pin_out_ff <= nxt_pin;
			// pin returns to port when off
			pin_oe_ff <= enabled && cfg.els != tim_cc_pkg::ELS_OFF && is_out;
		end
	end
endmodule : tim_cc_channel
`default_nettype wire

//--- hdl/tim_cc_top.sv
// Two-channel capture/compare/PWM block with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module tim_cc_top #(
	parameter int CHANNELS = 2
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Channel pins
	input wire logic [CHANNELS-1:0] channel_pin_in,
	output logic [CHANNELS-1:0] channel_pin_out,
	output logic [CHANNELS-1:0] channel_pin_oe,
	// Interrupt requests
	output logic [CHANNELS-1:0] chan_irq
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	tim_cc_pkg::chan_cfg_t cfg_ff [CHANNELS];
	logic [CHANNELS-1:0] flag_ff;
	logic [CHANNELS-1:0] flag_armed_ff;
	logic [15:0] value_ff [CHANNELS];
	logic [7:0] wr_high_ff [CHANNELS];
	logic [CHANNELS-1:0] cap_block_ff;
	logic [CHANNELS-1:0] match_block_ff;
	logic [15:0] count_ff;
	logic [15:0] mod_ff;
	logic halt_ff;
	logic cnt_ovf_flag_ff;
	logic [CHANNELS-1:0] pin_out;
	logic [CHANNELS-1:0] pin_oe;
	logic [CHANNELS-1:0] pin_rise;
	logic [CHANNELS-1:0] pin_fall;
	tim_cc_pkg::chan_evt_t evt [CHANNELS];
	logic [CHANNELS-1:0] chan_en;
	logic ovf_tick;
	logic cnt_clear;

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	logic aw_hold_ff;
	logic w_hold_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic wr_go;
	logic rd_go;
	logic [31:0] nxt_rdata;
	logic nxt_rd_ok;
	logic wr_ok;

	// Accept address and data in either order, then answer once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_hold_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (wr_go) begin
				w_hold_ff <= 1'b0;
			end
		end
	end

	assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tim_cc_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_hold_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? tim_cc_pkg::RESP_OKAY : tim_cc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= tim_cc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= nxt_rdata;
				s_axi_rresp <= nxt_rd_ok ? tim_cc_pkg::RESP_OKAY : tim_cc_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	function automatic logic [7:0] pack_ctrl(input logic flag, input tim_cc_pkg::chan_cfg_t c);
		pack_ctrl = {flag, c.irq_en, c.buf_sel, c.mode_a, c.els, c.ovf_tog, c.full_duty};
	endfunction : pack_ctrl

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_rd_ok = 1'b1;
		unique case (s_axi_araddr)
			tim_cc_pkg::ADDR_CHAN0_CTRL: nxt_rdata[7:0] = pack_ctrl(flag_ff[0], cfg_ff[0]);
			tim_cc_pkg::ADDR_CHAN1_CTRL: nxt_rdata[7:0] = pack_ctrl(flag_ff[1], cfg_ff[1]);
			tim_cc_pkg::ADDR_CHAN0_HIGH: nxt_rdata[7:0] = value_ff[0][15:8];
			tim_cc_pkg::ADDR_CHAN0_LOW: nxt_rdata[7:0] = value_ff[0][7:0];
			tim_cc_pkg::ADDR_CHAN1_HIGH: nxt_rdata[7:0] = value_ff[1][15:8];
			tim_cc_pkg::ADDR_CHAN1_LOW: nxt_rdata[7:0] = value_ff[1][7:0];
			tim_cc_pkg::ADDR_CNT_CTRL: begin
				nxt_rdata[tim_cc_pkg::BIT_CNT_OVF_FLAG] = cnt_ovf_flag_ff;
				nxt_rdata[tim_cc_pkg::BIT_CNT_HALT] = halt_ff;
			end
			tim_cc_pkg::ADDR_CNT_MOD: nxt_rdata[15:0] = mod_ff;
			tim_cc_pkg::ADDR_CNT_VALUE: nxt_rdata[15:0] = count_ff;
			tim_cc_pkg::ADDR_PIN_STATE: nxt_rdata[CHANNELS-1:0] = pin_out;
			default: nxt_rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		unique case (aw_addr_ff)
			tim_cc_pkg::ADDR_CHAN0_CTRL, tim_cc_pkg::ADDR_CHAN1_CTRL,
			tim_cc_pkg::ADDR_CHAN0_HIGH, tim_cc_pkg::ADDR_CHAN0_LOW,
			tim_cc_pkg::ADDR_CHAN1_HIGH, tim_cc_pkg::ADDR_CHAN1_LOW,
			tim_cc_pkg::ADDR_CNT_CTRL, tim_cc_pkg::ADDR_CNT_MOD,
			tim_cc_pkg::ADDR_CNT_VALUE, tim_cc_pkg::ADDR_PIN_STATE: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Shared counter
	// ------------------------------------------------------------
	assign cnt_clear = wr_go && w_strb_ff[0] && aw_addr_ff == tim_cc_pkg::ADDR_CNT_CTRL
		&& w_data_ff[tim_cc_pkg::BIT_CNT_CLEAR];
	assign ovf_tick = !halt_ff && !cnt_clear && count_ff == mod_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_ff <= 16'h0000;
			halt_ff <= 1'b1;
			mod_ff <= tim_cc_pkg::MOD_RESET;
			cnt_ovf_flag_ff <= 1'b0;
		end else begin
			if (cnt_clear)
				count_ff <= 16'h0000;
			else if (ovf_tick)
				count_ff <= 16'h0000;
			else if (!halt_ff)
				count_ff <= count_ff + 16'h0001;
			if (wr_go && w_strb_ff[0] && aw_addr_ff == tim_cc_pkg::ADDR_CNT_CTRL) begin
				halt_ff <= w_data_ff[tim_cc_pkg::BIT_CNT_HALT];
				if (!w_data_ff[tim_cc_pkg::BIT_CNT_OVF_FLAG] && !ovf_tick)
					cnt_ovf_flag_ff <= 1'b0;
			end
			if (ovf_tick)
				cnt_ovf_flag_ff <= 1'b1;
			if (wr_go && aw_addr_ff == tim_cc_pkg::ADDR_CNT_MOD) begin
				if (w_strb_ff[0])
					mod_ff[7:0] <= w_data_ff[7:0];
				if (w_strb_ff[1])
					mod_ff[15:8] <= w_data_ff[15:8];
			end
		end
	end

	// ------------------------------------------------------------
	// Per-channel registers and engines
	// ------------------------------------------------------------
	// channel 1 disabled by buffered select
	assign chan_en = {~cfg_ff[0].buf_sel, 1'b1};

	tim_cc_pin_sync #(
		.WIDTH(CHANNELS)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_async(channel_pin_in),
		.pin_rise(pin_rise),
		.pin_fall(pin_fall)
	);

	for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
		logic ctrl_rd;
		logic ctrl_wr;
		logic high_rd;
		logic low_rd;
		logic high_wr;
		logic low_wr;
		logic is_cap_mode;

		assign ctrl_rd = rd_go && s_axi_araddr == tim_cc_pkg::ADDR_CHAN0_CTRL + 8'(4 * i);
		assign ctrl_wr = wr_go && w_strb_ff[0] && chan_en[i]
			&& aw_addr_ff == tim_cc_pkg::ADDR_CHAN0_CTRL + 8'(4 * i);
		assign high_rd = rd_go && s_axi_araddr == tim_cc_pkg::ADDR_CHAN0_HIGH + 8'(8 * i);
		assign low_rd = rd_go && s_axi_araddr == tim_cc_pkg::ADDR_CHAN0_LOW + 8'(8 * i);
		assign high_wr = wr_go && w_strb_ff[0] && aw_addr_ff == tim_cc_pkg::ADDR_CHAN0_HIGH + 8'(8 * i);
		assign low_wr = wr_go && w_strb_ff[0] && aw_addr_ff == tim_cc_pkg::ADDR_CHAN0_LOW + 8'(8 * i);
		assign is_cap_mode = !cfg_ff[i].buf_sel && !cfg_ff[i].mode_a;

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cfg_ff[i] <= '0;
			end else if (ctrl_wr) begin
				cfg_ff[i].irq_en <= w_data_ff[tim_cc_pkg::BIT_IRQ_EN];
				// buffered bit only in channel 0
				cfg_ff[i].buf_sel <= (i == 0) ? w_data_ff[tim_cc_pkg::BIT_BUF_SEL] : 1'b0;
				cfg_ff[i].mode_a <= w_data_ff[tim_cc_pkg::BIT_MODE_A];
				cfg_ff[i].els <= w_data_ff[tim_cc_pkg::BIT_ELS_HI:tim_cc_pkg::BIT_ELS_LO];
				cfg_ff[i].ovf_tog <= w_data_ff[tim_cc_pkg::BIT_OVF_TOG];
				cfg_ff[i].full_duty <= w_data_ff[tim_cc_pkg::BIT_FULL_DUTY];
			end
		end

		// flag set wins; clear needs prior read
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				flag_ff[i] <= 1'b0;
				flag_armed_ff[i] <= 1'b0;
			end else if (evt[i].event_hit) begin
				flag_ff[i] <= 1'b1;
				flag_armed_ff[i] <= 1'b0;
			end else begin
				if (ctrl_rd && flag_ff[i])
					flag_armed_ff[i] <= 1'b1;
				if (ctrl_wr && !w_data_ff[tim_cc_pkg::BIT_FLAG] && flag_armed_ff[i]) begin
					flag_ff[i] <= 1'b0;
					flag_armed_ff[i] <= 1'b0;
				end
			end
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cap_block_ff[i] <= 1'b0;
				match_block_ff[i] <= 1'b0;
				wr_high_ff[i] <= 8'h00;
			end else begin
				if (high_rd && is_cap_mode)
					cap_block_ff[i] <= 1'b1;
				else if (low_rd)
					cap_block_ff[i] <= 1'b0;
				if (high_wr && !is_cap_mode) begin
					match_block_ff[i] <= 1'b1;
					wr_high_ff[i] <= w_data_ff[7:0];
				end else if (low_wr) begin
					match_block_ff[i] <= 1'b0;
				end
			end
		end

		// Value contents are left unreset on purpose
		always_ff @(posedge aclk) begin
			if (evt[i].event_hit && is_cap_mode)
				value_ff[i] <= evt[i].capture;
			else if (low_wr)
				value_ff[i] <= {match_block_ff[i] ? wr_high_ff[i] : value_ff[i][15:8], w_data_ff[7:0]};
			else if (high_wr && is_cap_mode)
				value_ff[i][15:8] <= w_data_ff[7:0];
		end

		tim_cc_channel u_chan (
			.aclk(aclk),
			.aresetn(aresetn),
			.cfg(cfg_ff[i]),
			.enabled(chan_en[i]),
			.count(count_ff),
			.compare(value_ff[i]),
			.ovf_tick(ovf_tick),
			// No match while halted, or a held count would fire every cycle
			.match_block(match_block_ff[i] | halt_ff),
			.capture_block(cap_block_ff[i]),
			.pin_rise(pin_rise[i]),
			.pin_fall(pin_fall[i]),
			.evt(evt[i]),
			.pin_out_ff(pin_out[i]),
			.pin_oe_ff(pin_oe[i])
		);

		always_ff @(posedge aclk) begin
			if (!aresetn)
				chan_irq[i] <= 1'b0;
			else
				chan_irq[i] <= flag_ff[i] & cfg_ff[i].irq_en;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_pin_out <= '0;
			channel_pin_oe <= '0;
		end else begin
			channel_pin_out <= pin_out;
			channel_pin_oe <= pin_oe;
		end
	end
endmodule : tim_cc_top
`default_nettype wire

//--- verif/tim_cc_pin_model.sv
// Far-side pin model for the two channel pins
`timescale 1ns/1ps
`default_nettype none
module tim_cc_pin_model (
	// Block side
	input wire logic [1:0] pin_out,
	input wire logic [1:0] pin_oe,
	// Level the port logic applies when the block lets go
	input wire logic [1:0] drive,
	// Resolved pin levels
	output logic [1:0] pin_in
);
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule : tim_cc_pin_model
`default_nettype wire

//--- verif/tim_cc_properties.sv
// Port-level assertions for the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module tim_cc_properties #(
	parameter int CHANNELS = 2
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and requests
	input wire logic [CHANNELS-1:0] channel_pin_in,
	input wire logic [CHANNELS-1:0] channel_pin_out,
	input wire logic [CHANNELS-1:0] channel_pin_oe,
	input wire logic [CHANNELS-1:0] chan_irq
);
	// Cycles since last write data taken; only software may drop requests or pin drive
	logic [3:0] since_wr_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || (s_axi_wvalid && s_axi_wready)) begin
			since_wr_ff <= 4'h0;
		end else if (since_wr_ff != 4'hf) begin
			since_wr_ff <= since_wr_ff + 4'h1;
		end
	end
	a_reset_quiet: assert property (@(posedge aclk) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && chan_irq == '0 && channel_pin_oe == '0)
		else $error("outputs active after reset");
	a_irq_drop_write: assert property (@(posedge aclk) disable iff (!aresetn) ($past(chan_irq) & ~chan_irq) != '0 |-> since_wr_ff < 4'h8)
		else $error("request dropped without a software write");
	a_oe_change_write: assert property (@(posedge aclk) disable iff (!aresetn) channel_pin_oe != $past(channel_pin_oe) |-> since_wr_ff < 4'h8)
		else $error("pin drive changed without a control write");
	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
		else $error("read data missing");
	a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h24 |-> ##[1:2] s_axi_rvalid && s_axi_rresp == tim_cc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_busy_refuse: assert property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answering");
endmodule : tim_cc_properties
bind tim_cc_top tim_cc_properties #(.CHANNELS(CHANNELS)) tim_cc_properties_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
	.chan_irq(chan_irq));
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the capture/compare block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0] drive = 2'h0;
	wire [1:0] pin_in, pin_out, pin_oe, irq, bresp, rresp;
	wire awready, wready, bvalid, arready, rvalid;
	wire [31:0] rdata;
	logic [1:0] qw[$];
	logic [65:0] qr[$];
	logic [65:0] re;
	logic [15:0] cmp;
	logic lvl;
	int ones;
	int n_mismatch = 0;
	int checked = 0;
	always #5 aclk = ~aclk;
	tim_cc_top tim_cc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
		.channel_pin_oe(pin_oe), .chan_irq(irq));
	tim_cc_pin_model tim_cc_pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .drive(drive), .pin_in(pin_in));
	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m, input string s);
		checked++;
		if ((g & m) !== (e & m)) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", s, e & m, g & m);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		int n;
		qw.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100 && !bvalid; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		@(posedge aclk);
		bready <= 1'b0;
		if (n == 100) begin
			n_mismatch++;
			test_done();
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hff,
		input logic [1:0] r = 2'h0);
		int n;
		qr.push_back({r, m, e});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100 && !rvalid; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		@(posedge aclk);
		rready <= 1'b0;
		if (n == 100) begin
			n_mismatch++;
			test_done();
		end
	endtask : rd
	// Clears and restarts the counter, runs n cycles, then halts it
	task automatic run(input int n);
		wr(tim_cc_pkg::ADDR_CNT_CTRL, 32'h30);
		wr(tim_cc_pkg::ADDR_CNT_CTRL, 32'h0);
		repeat (n) @(posedge aclk);
		wr(tim_cc_pkg::ADDR_CNT_CTRL, 32'h20);
	endtask : run
	task automatic duty(input int e_lo, input int e_hi, input string s);
		repeat (150) @(posedge aclk);
		ones = 0;
		repeat (98) begin
			@(posedge aclk);
			ones += pin_out[0];
		end
		chk(32'h1, {31'h0, ones >= e_lo && ones <= e_hi}, 32'h1, s);
	endtask : duty
	always @(posedge aclk) begin
		if (bvalid && bready) begin
			chk({30'h0, qw.pop_front()}, {30'h0, bresp}, 32'h3, "bresp");
		end
		if (rvalid && rready) begin
			re = qr.pop_front();
			chk({30'h0, re[65:64]}, {30'h0, rresp}, 32'h3, "rresp");
			chk(re[31:0], rdata, re[63:32], "rdata");
		end
	end
	initial begin
		void'($urandom(14));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(32'hc, {28'h0, pin_out, pin_oe}, 32'hf, "reset pins");
		rd(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h0);
		rd(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h0);
		rd(8'h40, 32'h0, 32'hffffffff, tim_cc_pkg::RESP_SLVERR);
		wr(8'h40, 32'h0, tim_cc_pkg::RESP_SLVERR);
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h80);
		rd(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h0);
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h10);
		repeat (4) @(posedge aclk);
		chk(32'h0, {28'h0, pin_out, pin_oe}, 32'h5, "preset low");
		// every capture edge setting, counter halted at zero
		for (int k = 1; k < 4; k++) begin
			wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h40 | (k << 2));
			repeat (8) @(posedge aclk);
			rd(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h0, 32'h0);
			wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h40 | (k << 2));
			drive <= 2'h1;
			repeat (8) @(posedge aclk);
			rd(tim_cc_pkg::ADDR_CHAN0_CTRL, (k[0] << 7) | 32'h40 | (k << 2));
			chk({31'h0, k[0]}, {30'h0, irq}, 32'h1, "irq");
			rd(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h0, 32'h0);
			wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h40 | (k << 2));
			drive <= 2'h0;
			repeat (8) @(posedge aclk);
			rd(tim_cc_pkg::ADDR_CHAN0_CTRL, (k[1] << 7) | 32'h40 | (k << 2));
		end
		rd(tim_cc_pkg::ADDR_CHAN0_HIGH, 32'h0);
		run(40);
		drive <= 2'h1;
		repeat (8) @(posedge aclk);
		rd(tim_cc_pkg::ADDR_CHAN0_LOW, 32'h0);
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h4c);
		rd(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h4c);
		drive <= 2'h0;
		repeat (8) @(posedge aclk);
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h4c);
		rd(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'hcc);
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h4c);
		rd(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h4c);
		drive <= 2'h1;
		repeat (8) @(posedge aclk);
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h0c);
		repeat (3) @(posedge aclk);
		chk(32'h0, {30'h0, irq}, 32'h1, "irq masked");
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h4c);
		repeat (3) @(posedge aclk);
		chk(32'h1, {30'h0, irq}, 32'h1, "irq unmasked");
		cmp = 16'h0010 + 16'($urandom % 64);
		// every compare pin action on channel 1
		for (int k = 0; k < 4; k++) begin
			wr(tim_cc_pkg::ADDR_CNT_CTRL, 32'h30);
			wr(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h10 | (k << 2));
			wr(tim_cc_pkg::ADDR_CHAN1_HIGH, {24'h0, cmp[15:8]});
			wr(tim_cc_pkg::ADDR_CHAN1_LOW, {24'h0, cmp[7:0]});
			rd(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h0, 32'h0);
			wr(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h10 | (k << 2));
			lvl = pin_out[1];
			run(120);
			rd(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h90 | (k << 2));
			chk({30'h0, (k == 1) ? ~lvl : (k == 3), k != 0}, {30'h0, pin_out[1], pin_oe[1]}, 32'h3, "cmp pin");
		end
		rd(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h0, 32'h0);
		wr(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h18);
		wr(tim_cc_pkg::ADDR_CHAN1_HIGH, {24'h0, cmp[15:8]});
		run(120);
		rd(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h18);
		wr(tim_cc_pkg::ADDR_CHAN1_LOW, {24'h0, cmp[7:0]});
		run(120);
		rd(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h98);
		wr(tim_cc_pkg::ADDR_CHAN0_HIGH, 32'h0);
		wr(tim_cc_pkg::ADDR_CHAN0_LOW, 32'h10);
		wr(tim_cc_pkg::ADDR_CNT_MOD, 32'h30);
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h2b);
		repeat (3) @(posedge aclk);
		chk(32'h1, {30'h0, pin_oe}, 32'h3, "buffered drive");
		wr(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h0);
		rd(tim_cc_pkg::ADDR_CHAN1_CTRL, 32'h18, 32'h7f);
		wr(tim_cc_pkg::ADDR_CNT_CTRL, 32'h10);
		duty(98, 98, "full duty");
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h2a);
		duty(1, 97, "pwm duty");
		wr(tim_cc_pkg::ADDR_CHAN0_CTRL, 32'h28);
		duty(0, 0, "zero duty");
		repeat (4) @(posedge aclk);
		test_done();
	end
endmodule : testbench
`default_nettype wire
